//--- verilog/stage_irq_pkg.sv
// Purpose: Shared constants and carriers for the stage interrupt flag block
// Assumes: Eight conversion stages, 16-bit registers on a word-addressed port
// Notes:   Upper eight bits of every register here read as zero
package stage_irq_pkg;

   // ==========================================================================
   // Sizes
   localparam int NUM_STAGES = 8;
   localparam int REG_W      = 16;
   localparam int ADDR_W     = 10;

   // ==========================================================================
   // Register offsets
   localparam logic [ADDR_W-1:0] LOW_TRIP_EN_OFS  = 10'h005;
   localparam logic [ADDR_W-1:0] HIGH_TRIP_EN_OFS = 10'h006;
   localparam logic [ADDR_W-1:0] DONE_EN_OFS      = 10'h007;
   localparam logic [ADDR_W-1:0] LOW_FLAGS_OFS    = 10'h008;
   localparam logic [ADDR_W-1:0] HIGH_FLAGS_OFS   = 10'h009;
   localparam logic [ADDR_W-1:0] DONE_FLAGS_OFS   = 10'h00A;

   // ==========================================================================
   // Reset values
   localparam logic [NUM_STAGES-1:0] ENABLE_RST = 8'h00;
   localparam logic [NUM_STAGES-1:0] FLAGS_RST  = 8'h00;
   localparam logic [REG_W-1:0]      RDATA_RST  = 16'h0000;

   // ==========================================================================
   // Carriers
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic              wr;
      logic              rd;
      logic [REG_W-1:0]  wdata;
   } reg_req_t;

   typedef struct packed {
      logic [NUM_STAGES-1:0] stageDone;
      logic [NUM_STAGES-1:0] lowTrip;
      logic [NUM_STAGES-1:0] highTrip;
   } stage_evt_t;

endpackage

//--- verilog/stage_interrupt_flags.sv
// Purpose: Per-stage enable and flag registers driving the active-low interrupt
// Assumes: Register port is the serial interface's internal word access
// Notes:   Flags clear on readback unless their limit condition still holds
`timescale 1ns/100ps
`default_nettype none

module stage_interrupt_flags (
   input  wire logic                               clk_sys,
   input  wire logic                               rst,
   input  wire stage_irq_pkg::reg_req_t            regReq,
   input  wire stage_irq_pkg::stage_evt_t          stageEvt,
   output logic [stage_irq_pkg::REG_W-1:0]         rdData,
   output logic                                    rdValid,
   output logic                                    irqN
);

   // =========================================================================
   // Address decode
   function automatic logic hitReg(input logic [stage_irq_pkg::ADDR_W-1:0] a,
                                   input logic [stage_irq_pkg::ADDR_W-1:0] ofs);
      hitReg = (a == ofs);
   endfunction

   logic [stage_irq_pkg::NUM_STAGES-1:0] lowEnReg;
   logic [stage_irq_pkg::NUM_STAGES-1:0] highEnReg;
   logic [stage_irq_pkg::NUM_STAGES-1:0] doneEnReg;
   logic [stage_irq_pkg::NUM_STAGES-1:0] lowFlagReg;
   logic [stage_irq_pkg::NUM_STAGES-1:0] highFlagReg;
   logic [stage_irq_pkg::NUM_STAGES-1:0] doneFlagReg;
   logic [stage_irq_pkg::NUM_STAGES-1:0] lowFlagNext;
   logic [stage_irq_pkg::NUM_STAGES-1:0] highFlagNext;
   logic [stage_irq_pkg::NUM_STAGES-1:0] doneFlagNext;
   logic [stage_irq_pkg::REG_W-1:0]      rdData_next;
   logic [stage_irq_pkg::NUM_STAGES-1:0] rdSel;
   logic                                 irqN_next;
   logic [stage_irq_pkg::NUM_STAGES-1:0] lowEn_next;
   logic [stage_irq_pkg::NUM_STAGES-1:0] highEn_next;
   logic [stage_irq_pkg::NUM_STAGES-1:0] doneEn_next;
   logic [stage_irq_pkg::NUM_STAGES-1:0] srcHit;

   wire wrLowEn   = regReq.wr && hitReg(regReq.addr, stage_irq_pkg::LOW_TRIP_EN_OFS);
   wire wrHighEn  = regReq.wr && hitReg(regReq.addr, stage_irq_pkg::HIGH_TRIP_EN_OFS);
   wire wrDoneEn  = regReq.wr && hitReg(regReq.addr, stage_irq_pkg::DONE_EN_OFS);
   wire rdLowEn   = regReq.rd && hitReg(regReq.addr, stage_irq_pkg::LOW_TRIP_EN_OFS);
   wire rdHighEn  = regReq.rd && hitReg(regReq.addr, stage_irq_pkg::HIGH_TRIP_EN_OFS);
   wire rdDoneEn  = regReq.rd && hitReg(regReq.addr, stage_irq_pkg::DONE_EN_OFS);
   wire rdLowFl   = regReq.rd && hitReg(regReq.addr, stage_irq_pkg::LOW_FLAGS_OFS);
   wire rdHighFl  = regReq.rd && hitReg(regReq.addr, stage_irq_pkg::HIGH_FLAGS_OFS);
   wire rdDoneFl  = regReq.rd && hitReg(regReq.addr, stage_irq_pkg::DONE_FLAGS_OFS);

   // =========================================================================
   // Flag update: a set in the clearing cycle wins over the readback clear
   assign lowFlagNext  = (rdLowFl  ? '0 : lowFlagReg)  | stageEvt.lowTrip;
   assign highFlagNext = (rdHighFl ? '0 : highFlagReg) | stageEvt.highTrip;
   assign doneFlagNext = (rdDoneFl ? '0 : doneFlagReg) | stageEvt.stageDone;

   // =========================================================================
   // Enable next values; a new mask reaches the pin with the register itself
   assign lowEn_next  = wrLowEn  ? regReq.wdata[7:0] : lowEnReg;
   assign highEn_next = wrHighEn ? regReq.wdata[7:0] : highEnReg;
   assign doneEn_next = wrDoneEn ? regReq.wdata[7:0] : doneEnReg;

   // =========================================================================
   // Interrupt from next flags and masks, so the pin never lags a mask write
   for (genvar s = 0; s < stage_irq_pkg::NUM_STAGES; s++) begin : gen_src
      assign srcHit[s] = (doneFlagNext[s] & doneEn_next[s])
                       | (lowFlagNext[s] & lowEn_next[s])
                       | (highFlagNext[s] & highEn_next[s]);
   end
   assign irqN_next = ~(|srcHit);

   // =========================================================================
   // Read mux; unmapped addresses read zero
   assign rdSel = ({stage_irq_pkg::NUM_STAGES{rdLowEn}}  & lowEnReg)
                | ({stage_irq_pkg::NUM_STAGES{rdHighEn}} & highEnReg)
                | ({stage_irq_pkg::NUM_STAGES{rdDoneEn}} & doneEnReg)
                | ({stage_irq_pkg::NUM_STAGES{rdLowFl}}  & lowFlagReg)
                | ({stage_irq_pkg::NUM_STAGES{rdHighFl}} & highFlagReg)
                | ({stage_irq_pkg::NUM_STAGES{rdDoneFl}} & doneFlagReg);
   assign rdData_next = {8'h00, rdSel};

   // =========================================================================
   // Enable registers; upper write bits dropped, so stray ones do no harm
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         lowEnReg  <= stage_irq_pkg::ENABLE_RST;
         highEnReg <= stage_irq_pkg::ENABLE_RST;
         doneEnReg <= stage_irq_pkg::ENABLE_RST;
      end else begin
         lowEnReg  <= lowEn_next;
         highEnReg <= highEn_next;
         doneEnReg <= doneEn_next;
      end
   end

   // =========================================================================
   // Flags, read data and interrupt pin
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         lowFlagReg  <= stage_irq_pkg::FLAGS_RST;
         highFlagReg <= stage_irq_pkg::FLAGS_RST;
         doneFlagReg <= stage_irq_pkg::FLAGS_RST;
         rdData      <= stage_irq_pkg::RDATA_RST;
         rdValid     <= 1'b0;
         irqN        <= 1'b1;
      end else begin
         lowFlagReg  <= lowFlagNext;
         highFlagReg <= highFlagNext;
         doneFlagReg <= doneFlagNext;
         rdValid     <= regReq.rd;
         if (regReq.rd) rdData <= rdData_next;
         irqN        <= irqN_next;
      end
   end

   // =========================================================================
   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence doneUnread;
      (|(stageEvt.stageDone & doneEnReg)) && !wrDoneEn;
   endsequence

   sequence lowReadback;
      rdLowFl ##1 rdValid;
   endsequence

   sequence doneReadback;
      rdDoneFl ##1 rdValid;
   endsequence

   chk_done_en_write: assert property (wrDoneEn |=>
      doneEnReg == $past(regReq.wdata[7:0]))
      else $error("done enable register did not take written value");

   chk_done_irq_fires: assert property (doneUnread |=> !irqN)
      else $error("enabled stage completion did not assert interrupt");

   chk_irq_or_sources: assert property (irqN == !(|((doneFlagReg & doneEnReg)
      | (lowFlagReg & lowEnReg) | (highFlagReg & highEnReg))))
      else $error("interrupt pin disagrees with enabled flags");

   chk_disabled_quiet: assert property ((lowEnReg == 8'h00 && highEnReg == 8'h00
      && doneEnReg == 8'h00) |-> irqN)
      else $error("interrupt asserted with all sources disabled");

   chk_low_flag_set: assert property ((|stageEvt.lowTrip) |=>
      ((lowFlagReg & $past(stageEvt.lowTrip)) == $past(stageEvt.lowTrip)))
      else $error("low trip did not set its flag");

   chk_high_flag_set: assert property ((|stageEvt.highTrip) |=>
      ((highFlagReg & $past(stageEvt.highTrip)) == $past(stageEvt.highTrip)))
      else $error("high trip did not set its flag");

   chk_low_read_clear: assert property (lowReadback |->
      (lowFlagReg == $past(stageEvt.lowTrip)) && (rdData[7:0] == $past(lowFlagReg)))
      else $error("low flag readback clear or data wrong");

   chk_high_read_clear: assert property (rdHighFl |=>
      (highFlagReg == $past(stageEvt.highTrip)) && rdData == {8'h00, $past(highFlagReg)})
      else $error("high flag readback clear or data wrong");

   chk_done_flag_set: assert property ((|stageEvt.stageDone) |=>
      ((doneFlagReg & $past(stageEvt.stageDone)) == $past(stageEvt.stageDone)))
      else $error("stage completion did not set its flag");

   chk_read_upper_zero: assert property (rdValid |-> rdData[15:8] == 8'h00)
      else $error("upper read bits not zero");

   chk_low_irq_fires: assert property ((|(stageEvt.lowTrip & lowEn_next)) |=>
      !irqN)
      else $error("enabled low trip did not assert interrupt");

   chk_high_irq_fires: assert property ((|(stageEvt.highTrip & highEn_next)) |=>
      !irqN)
      else $error("enabled high trip did not assert interrupt");

   chk_rd_valid_pulse: assert property (regReq.rd |=>
      rdValid)
      else $error("read answer missing one cycle after read");

   chk_rd_valid_idle: assert property (!regReq.rd |=>
      !rdValid)
      else $error("read answer without a read");

   chk_done_read_clear: assert property (doneReadback |->
      (doneFlagReg == $past(stageEvt.stageDone)) && (rdData[7:0] == $past(doneFlagReg)))
      else $error("done flag readback clear or data wrong");

   chk_low_flag_hold: assert property (!rdLowFl |=>
      ((lowFlagReg & $past(lowFlagReg)) == $past(lowFlagReg)))
      else $error("low flag dropped without readback");

   chk_high_flag_hold: assert property (!rdHighFl |=>
      ((highFlagReg & $past(highFlagReg)) == $past(highFlagReg)))
      else $error("high flag dropped without readback");

   chk_done_en_hold: assert property (!wrDoneEn |=>
      $stable(doneEnReg))
      else $error("done enable changed without a write");

   chk_low_en_hold: assert property (!wrLowEn |=>
      $stable(lowEnReg))
      else $error("low enable changed without a write");

   chk_high_en_hold: assert property (!wrHighEn |=>
      $stable(highEnReg))
      else $error("high enable changed without a write");

endmodule

`default_nettype wire

//--- tb/host_model.sv
// Purpose: Host side of the register port, word reads and writes
// Assumes: Requests launch on the falling edge of clk_sys
// Notes:   Idle write data shows the inverse of its last value
`timescale 1ns/100ps
`default_nettype none
module host_model (
   input  wire logic                              clk_sys,
   input  wire logic [stage_irq_pkg::REG_W-1:0]   rdData,
   input  wire logic                              rdValid,
   output var  stage_irq_pkg::reg_req_t           regReq
);
   // ==========================================================================
   // Bus cycles
   initial regReq = '0;
   task automatic wr_reg(input logic [stage_irq_pkg::ADDR_W-1:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      regReq = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: {8'h00, d}};
      @(negedge clk_sys);
      regReq.wr = 1'b0;
      regReq.wdata = ~regReq.wdata;
   endtask
   task automatic rd_reg(input logic [stage_irq_pkg::ADDR_W-1:0] a, output logic [15:0] d);
      @(negedge clk_sys);
      regReq.addr = a;
      regReq.rd = 1'b1;
      @(negedge clk_sys);
      regReq.rd = 1'b0;
      // Bounded wait so a missing answer cannot hang the run
      for (int i = 0; i < 4 && rdValid !== 1'b1; i++) @(negedge clk_sys);
      d = (rdValid === 1'b1) ? rdData : 'x;
   endtask
endmodule
`default_nettype wire

//--- tb/stage_interrupt_flags_test.sv
// Purpose: Self-checking bench for the stage interrupt flag block
// Assumes: Host model issues all register traffic
// Notes:   Release of irqN is judged one cycle after the read answer
`timescale 1ns/100ps
`default_nettype none
module stage_interrupt_flags_test;
   logic                       clk_sys;
   logic                       rst;
   stage_irq_pkg::reg_req_t    regReq;
   stage_irq_pkg::stage_evt_t  stageEvt;
   logic [15:0]                rdData;
   logic                       rdValid;
   logic                       irqN;
   int                         error_cnt = 0;
   int                         total_checks = 0;
   stage_interrupt_flags uut (.clk_sys(clk_sys), .rst(rst), .regReq(regReq),
      .stageEvt(stageEvt), .rdData(rdData), .rdValid(rdValid), .irqN(irqN));
   host_model host (.clk_sys(clk_sys), .rdData(rdData), .rdValid(rdValid), .regReq(regReq));
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   // ==========================================================================
   // Helpers
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic rd_chk(input string n, input logic [9:0] a, input logic [15:0] e);
      logic [15:0] d;
      host.rd_reg(a, d);
      chk(n, e, d);
   endtask
   task automatic pulse_done(input logic [7:0] m);
      @(negedge clk_sys) stageEvt.stageDone = m;
      @(negedge clk_sys) stageEvt.stageDone = 8'h00;
   endtask
   // ==========================================================================
   // Scenarios
   task automatic reset_values();
      rd_chk("done_en", 10'h007, 16'h0000);
      rd_chk("low_flags", 10'h008, 16'h0000);
      rd_chk("high_flags", 10'h009, 16'h0000);
      rd_chk("done_flags", 10'h00A, 16'h0000);
   endtask
   task automatic done_irq();
      host.wr_reg(10'h007, 8'hFF);
      rd_chk("done_en_rw", 10'h007, 16'h00FF);
      host.wr_reg(10'h007, 8'h04);
      repeat (2) @(negedge clk_sys);
      pulse_done(8'h04);
      chk("irq_done", 16'h0000, {15'h0, irqN});
      rd_chk("done_flag2", 10'h00A, 16'h0004);
      @(negedge clk_sys);
      chk("irq_release", 16'h0001, {15'h0, irqN});
      pulse_done(8'h20);
      @(negedge clk_sys);
      chk("irq_masked", 16'h0001, {15'h0, irqN});
      rd_chk("done_flag5", 10'h00A, 16'h0020);
   endtask
   // Same walk for both limits: the hold while tripped is the awkward case
   task automatic trip(input bit hi, input logic [7:0] m);
      host.wr_reg(hi ? 10'h006 : 10'h005, m);
      repeat (2) @(negedge clk_sys);
      if (hi) stageEvt.highTrip = m;
      else stageEvt.lowTrip = m;
      repeat (2) @(negedge clk_sys);
      chk("irq_trip", 16'h0000, {15'h0, irqN});
      rd_chk("trip_set", hi ? 10'h009 : 10'h008, {8'h00, m});
      stageEvt.lowTrip = 8'h00;
      stageEvt.highTrip = 8'h00;
      rd_chk("trip_held", hi ? 10'h009 : 10'h008, {8'h00, m});
      rd_chk("trip_clear", hi ? 10'h009 : 10'h008, 16'h0000);
      @(negedge clk_sys);
      chk("irq_trip_off", 16'h0001, {15'h0, irqN});
   endtask
   task automatic regs_rw();
      host.wr_reg(10'h005, 8'hA5);
      host.wr_reg(10'h006, 8'h5A);
      rd_chk("low_en_rw", 10'h005, 16'h00A5);
      rd_chk("high_en_rw", 10'h006, 16'h005A);
      host.wr_reg(10'h008, 8'hFF);
      rd_chk("low_ro", 10'h008, 16'h0000);
      rd_chk("unmapped", 10'h003, 16'h0000);
      host.wr_reg(10'h005, 8'h00);
      host.wr_reg(10'h006, 8'h00);
   endtask
   // A mask written over a standing flag must move the pin at once
   task automatic mask_now();
      host.wr_reg(10'h007, 8'h00);
      pulse_done(8'h08);
      chk("irq_off_masked", 16'h0001, {15'h0, irqN});
      host.wr_reg(10'h007, 8'h08);
      chk("irq_unmask", 16'h0000, {15'h0, irqN});
      host.wr_reg(10'h007, 8'h00);
      chk("irq_remask", 16'h0001, {15'h0, irqN});
      rd_chk("done_flag3", 10'h00A, 16'h0008);
   endtask
   task automatic mid_reset();
      host.wr_reg(10'h007, 8'hFF);
      pulse_done(8'h81);
      chk("irq_pre_rst", 16'h0000, {15'h0, irqN});
      @(negedge clk_sys) rst = 1'b1;
      repeat (2) @(negedge clk_sys);
      rst = 1'b0;
      chk("irq_rst", 16'h0001, {15'h0, irqN});
      reset_values();
      rd_chk("low_en_rst", 10'h005, 16'h0000);
      rd_chk("high_en_rst", 10'h006, 16'h0000);
   endtask
   // ==========================================================================
   // Run control
   task automatic finish_test();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #200000;
      error_cnt++;
      finish_test();
   end
   initial begin
      stageEvt = '0;
      rst = 1'b1;
      repeat (20) @(negedge clk_sys);
      rst = 1'b0;
      reset_values();
      regs_rw();
      done_irq();
      mask_now();
      trip(1'b0, 8'h02);
      trip(1'b1, 8'h40);
      mid_reset();
      finish_test();
   end
endmodule
`default_nettype wire
